// file: hw/pcc_regs.svh
// Register offsets, field positions and reset values of the calibration config bank
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH
`define PCC_ADDR_CALIB_CONFIG 8'hd9
`define PCC_ADDR_CALIB_STATUS 8'hdc
`define PCC_ADDR_IRQ_ENABLE 8'hdd
`define PCC_RST_CALIB_CONFIG 8'h50
`define PCC_RST_CALIB_STATUS 8'h00
`define PCC_RST_IRQ_ENABLE 8'h00
`define PCC_GOAL_HI 7
`define PCC_GOAL_LO 5
`define PCC_TRIM_BIT 3
`define PCC_AVG_HI 2
`define PCC_AVG_LO 0
`define PCC_DONE_BIT 0
`define PCC_IEN_LSAT 7
`define PCC_IEN_NSAT 6
`define PCC_IEN_NTHR 5
`define PCC_IEN_LTHR 4
`define PCC_IEN_CAL 3
`define PCC_IEN_MASK 8'hf8
`endif

// file: hw/pcc_pkg.sv
// Types shared by the calibration config bank
`default_nettype none
package pcc_pkg;
    // Register access request from the serial bus front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcc_req_s;
    // Raw interrupt sources from the sensing engines
    typedef struct packed {
        logic light_sat;
        logic near_sat;
        logic near_threshold_flag;
        logic light_threshold_flag;
        logic calibration_flag;
    } pcc_flags_s;
    typedef enum logic [1:0] {PCC_IDLE, PCC_SEARCH, PCC_LOAD} pcc_cal_e;
endpackage
`default_nettype wire

// file: hw/pcc_calib_bank.sv
// Proximity calibration config, calibration status and interrupt enable registers
// Behaviour
// - goal code n selects calibration target 2^n-1, 0 to 127.
// - calibration steers offset toward the target while keeping result above zero.
// - with self trim set, zero result at cycle end while idle decrements a nonzero offset magnitude.
// - averaging code 0 disables; code n averages 2^n samples up to 128.
// - done flag sets when an offset calibration sequence finishes.
// - done flag clears only on host write of one; zero leaves it.
// - five interrupt enables at bits 7..3, all reset to zero.
// - interrupt output asserts when any flag and its enable are both set.
// - at calibration end load offset magnitude and sign, raise calibration flag.
`timescale 1ns/1ps
`default_nettype none
`include "pcc_regs.svh"
module pcc_calib_bank (
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Register access, same clock domain
    input wire pcc_pkg::pcc_req_s req_in,
    output logic [7:0] rdata_out,
    // Proximity engine
    input wire logic cal_start_in,
    input wire logic cycle_done_in,
    input wire logic [7:0] near_result_in,
    output logic [7:0] calib_search_goal_out,
    output logic [7:0] avg_samples_out,
    output logic avg_enable_out,
    output logic [7:0] offset_magnitude_out,
    output logic offset_sign_out,
    output logic offset_load_out,
    output logic offset_trim_out,
    output logic cal_busy_out,
    // Interrupts
    input wire pcc_pkg::pcc_flags_s flags_in,
    output logic calibration_flag_out,
    output logic irq_out
);
    import pcc_pkg::*;

    logic [7:0] calib_config;
    logic calibration_done_flag;
    logic [4:0] irq_en;
    pcc_cal_e state;
    logic [7:0] trial;
    logic [7:0] bitmask;
    logic wr_cfg;
    logic wr_sts;
    logic wr_ien;
    logic cal_end;
    logic trim_hit;

    // Address match, shared by read and write decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    assign wr_cfg = req_in.wr && hit(req_in.addr, `PCC_ADDR_CALIB_CONFIG);
    assign wr_sts = req_in.wr && hit(req_in.addr, `PCC_ADDR_CALIB_STATUS);
    assign wr_ien = req_in.wr && hit(req_in.addr, `PCC_ADDR_IRQ_ENABLE);

    // Config register; reserved bit 4 is stored as written, host keeps it at one
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            calib_config <= `PCC_RST_CALIB_CONFIG;
        end else if (wr_cfg) begin
            calib_config <= req_in.wdata;
        end
    end

    // Goal is 2^n-1 as an 8-bit mask of n ones
    assign calib_search_goal_out = 8'(({1'b0, 8'h01} << calib_config[`PCC_GOAL_HI:`PCC_GOAL_LO]) - 9'h001);
    // Sample count 2^n, code 0 means averaging off
    assign avg_enable_out = calib_config[`PCC_AVG_HI:`PCC_AVG_LO] != 3'h0;
    assign avg_samples_out = 8'h01 << calib_config[`PCC_AVG_HI:`PCC_AVG_LO];
    assign offset_trim_out = calib_config[`PCC_TRIM_BIT];

    // Binary search over offset magnitude, MSB first; larger offset lowers result
    assign cal_end = (state == PCC_LOAD);
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state <= PCC_IDLE;
            trial <= 8'h00;
            bitmask <= 8'h00;
        end else begin
            unique case (state)
                PCC_IDLE: begin
                    if (cal_start_in) begin
                        state <= PCC_SEARCH;
                        trial <= 8'h80;
                        bitmask <= 8'h80;
                    end
                end
                PCC_SEARCH: begin
                    // A cycle measured before the trial reached the offset register is stale
                    if (cycle_done_in && offset_magnitude_out == trial) begin
                        // Drop the trial bit if result fell to or below goal, never zero
                        if (near_result_in <= calib_search_goal_out) begin
                            trial <= (trial & ~bitmask) | (bitmask >> 1);
                        end else begin
                            trial <= trial | (bitmask >> 1);
                        end
                        bitmask <= bitmask >> 1;
                        if (bitmask == 8'h01) begin
                            state <= PCC_LOAD;
                            if (near_result_in <= calib_search_goal_out) begin
                                trial <= trial & ~bitmask;
                            end
                        end
                    end
                end
                PCC_LOAD: begin
                    state <= PCC_IDLE;
                end
            endcase
        end
    end
    assign cal_busy_out = (state != PCC_IDLE);

    // Offset magnitude: loaded at calibration end, trimmed on zero result
    assign trim_hit = offset_trim_out && cycle_done_in && (state == PCC_IDLE)
        && (near_result_in == 8'h00) && (offset_magnitude_out != 8'h00);
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            offset_magnitude_out <= 8'h00;
            offset_sign_out <= 1'b0;
            offset_load_out <= 1'b0;
        end else begin
            offset_load_out <= cal_end || trim_hit;
            if (cal_end) begin
                offset_magnitude_out <= trial;
                offset_sign_out <= 1'b0;
            end else if (trim_hit) begin
                offset_magnitude_out <= offset_magnitude_out - 8'h01;
            end else if (state == PCC_SEARCH) begin
                offset_magnitude_out <= trial;
            end
        end
    end

    // Done flag and calibration interrupt flag; set wins over a same-cycle clear
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            calibration_done_flag <= 1'b0;
            calibration_flag_out <= 1'b0;
        end else begin
            if (cal_end) begin
                calibration_done_flag <= 1'b1;
                calibration_flag_out <= 1'b1;
            end else if (wr_sts && req_in.wdata[`PCC_DONE_BIT]) begin
                calibration_done_flag <= 1'b0;
                calibration_flag_out <= 1'b0;
            end
        end
    end

    // Interrupt enable register, bits 2:0 read as zero
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            irq_en <= 5'(`PCC_RST_IRQ_ENABLE >> `PCC_IEN_CAL);
        end else if (wr_ien) begin
            irq_en <= req_in.wdata[`PCC_IEN_LSAT:`PCC_IEN_CAL];
        end
    end

    // Any enabled flag drives the interrupt
    assign irq_out = |(irq_en & {flags_in.light_sat, flags_in.near_sat,
        flags_in.near_threshold_flag, flags_in.light_threshold_flag,
        flags_in.calibration_flag | calibration_flag_out});

    // Registered read data, unmapped addresses read zero
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rdata_out <= 8'h00;
        end else if (req_in.rd) begin
            if (hit(req_in.addr, `PCC_ADDR_CALIB_CONFIG)) begin
                rdata_out <= calib_config;
            end else if (hit(req_in.addr, `PCC_ADDR_CALIB_STATUS)) begin
                rdata_out <= {7'h00, calibration_done_flag};
            end else if (hit(req_in.addr, `PCC_ADDR_IRQ_ENABLE)) begin
                rdata_out <= {irq_en, 3'h0};
            end else begin
                rdata_out <= 8'h00;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    goal_decode_a: assert property ($countones(calib_search_goal_out) ==
        int'(calib_config[`PCC_GOAL_HI:`PCC_GOAL_LO])
        && (8'(calib_search_goal_out + 8'h01) & calib_search_goal_out) == 8'h00)
        else $error("goal decode wrong");
    done_set_a: assert property (cal_end |=> calibration_done_flag)
        else $error("done not set");
    avg_count_a: assert property ($countones(avg_samples_out) == 1
        && avg_samples_out[calib_config[`PCC_AVG_HI:`PCC_AVG_LO]]
        && avg_enable_out == (avg_samples_out != 8'h01))
        else $error("averaging count wrong");
    trim_dec_a: assert property (trim_hit |=>
        offset_magnitude_out == $past(offset_magnitude_out) - 8'h01)
        else $error("trim not decremented");
    done_hold_a: assert property (calibration_done_flag
        && !(wr_sts && req_in.wdata[`PCC_DONE_BIT]) |=> calibration_done_flag)
        else $error("done flag lost");
    done_clear_a: assert property (calibration_done_flag && wr_sts
        && req_in.wdata[`PCC_DONE_BIT] && !cal_end |=> !calibration_done_flag)
        else $error("done flag not cleared");
    cal_load_a: assert property (cal_end |=> offset_load_out && calibration_flag_out
        && offset_magnitude_out == $past(trial)) else $error("calibration load wrong");
    irq_cal_a: assert property (irq_en[0] && calibration_flag_out |-> irq_out)
        else $error("interrupt missing");
    ien_write_a: assert property (wr_ien && req_in.rd == 1'b0
        |=> irq_en == $past(req_in.wdata[7:3])) else $error("enable write lost");
    // Eight accepted cycles, each needing the trial to settle first, keep the search long
    search_len_a: assert property ($rose(state == PCC_SEARCH)
        |-> (state == PCC_SEARCH)[*8]) else $error("search too short");
    start_take_a: assert property (state == PCC_IDLE && cal_start_in
        |=> state == PCC_SEARCH) else $error("start not taken");

    cal_run_c: cover property (state == PCC_SEARCH ##[1:100] cal_end);
    keep_c: cover property (wr_sts && !req_in.wdata[0] && calibration_done_flag);
    trim_c: cover property (trim_hit);
    irq_c: cover property ($rose(irq_out));
    clear_c: cover property (wr_sts && req_in.wdata[0] && calibration_done_flag);
endmodule
`default_nettype wire

// file: testbench/pcc_engine_model.sv
// Proximity engine stand-in: periodic cycles whose result is crosstalk minus offset
`timescale 1ns/1ps
`default_nettype none
module pcc_engine_model (
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Offset from the bank and crosstalk of the scene
    input wire logic [7:0] offset_in,
    input wire logic [7:0] xtalk_in,
    // Cycle results
    output logic done_out,
    output logic [7:0] result_out
);
    logic [1:0] phase;
    // One cycle every four clocks gives each trial offset time to settle
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end
    // Result floors at zero and is scrambled outside its valid cycle
    assign done_out = (phase == 2'h3);
    assign result_out = !done_out ? ~offset_in :
        (xtalk_in > offset_in) ? xtalk_in - offset_in : 8'h00;
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the calibration config bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pcc_pkg::*;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    pcc_req_s req_in = '0;
    pcc_flags_s flags_in = '0;
    logic cal_start_in = 1'b0;
    logic [7:0] xtalk = 8'h64;
    logic [7:0] rdata_out, goal, avg_n, mag, v, result;
    logic avg_en, sign, load, trim, busy, cflag, irq, cyc_done;
    int err_total = 0;
    int compares = 0;
    int i;
    // Rows: write flag, address, write data, expected read back
    logic [24:0] rows [0:7] = '{{1'b0, 8'hd9, 8'h00, 8'h50}, {1'b0, 8'hdc, 8'h00, 8'h00},
        {1'b0, 8'hdd, 8'h00, 8'h00}, {1'b1, 8'hdd, 8'hff, 8'hf8}, {1'b1, 8'hdd, 8'h00, 8'h00},
        {1'b1, 8'h10, 8'hff, 8'h00}, {1'b1, 8'hdc, 8'hff, 8'h00}, {1'b1, 8'hd9, 8'h5a, 8'h5a}};
    pcc_calib_bank pcc_calib_bank_i (.clock_in(clock_in), .srst_in(srst_in), .req_in(req_in),
        .rdata_out(rdata_out), .cal_start_in(cal_start_in), .cycle_done_in(cyc_done),
        .near_result_in(result), .calib_search_goal_out(goal), .avg_samples_out(avg_n),
        .avg_enable_out(avg_en), .offset_magnitude_out(mag), .offset_sign_out(sign),
        .offset_load_out(load), .offset_trim_out(trim), .cal_busy_out(busy),
        .flags_in(flags_in), .calibration_flag_out(cflag), .irq_out(irq));
    pcc_engine_model pcc_engine_model_i (.clock_in(clock_in), .srst_in(srst_in),
        .offset_in(mag), .xtalk_in(xtalk), .done_out(cyc_done), .result_out(result));
    // Free-running 100 MHz clock
    always #5 clock_in = ~clock_in;
    task automatic end_sim;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask
    // Requests change just after the edge and last exactly one cycle
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in) #1 req_in = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock_in) #1 req_in = '0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_in) #1 req_in = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock_in) #1 req_in = '0;
        @(posedge clock_in) #1 d = rdata_out;
    endtask
    initial begin
        repeat (20) @(posedge clock_in);
        #1 srst_in = 1'b0;
        // Reset values, masks, unmapped place, reserved bits kept as written
        foreach (rows[r]) begin
            if (rows[r][24]) wr_reg(rows[r][23:16], rows[r][15:8]);
            rd_reg(rows[r][23:16], v);
            chk("row", rows[r][7:0], v);
        end
        // Every goal and averaging code
        for (i = 0; i < 8; i++) begin
            wr_reg(8'hd9, {i[2:0], 1'b1, i[0], i[2:0]});
            chk("goal", (8'h01 << i) - 8'h01, goal);
            chk("avg", 8'h01 << i, avg_n);
            chk("avg_en", {7'h0, i != 0}, {7'h0, avg_en});
            chk("trim", {7'h0, i[0]}, {7'h0, trim});
        end
        // Each source alone with its own enable, then with all the others
        for (i = 0; i < 5; i++) begin
            flags_in = pcc_flags_s'(5'h01 << i);
            wr_reg(8'hdd, 8'h08 << i);
            chk("irq_on", 8'h01, {7'h0, irq});
            wr_reg(8'hdd, ~(8'h08 << i) & 8'hf8);
            chk("irq_off", 8'h00, {7'h0, irq});
        end
        flags_in = '0;
        wr_reg(8'hdd, 8'h08);
        // Calibration against crosstalk 100 with goal 3 settles at 96
        wr_reg(8'hd9, 8'h50);
        @(posedge clock_in) #1 cal_start_in = 1'b1;
        @(posedge clock_in) #1 cal_start_in = 1'b0;
        for (i = 0; i < 300 && busy === 1'b1; i++) @(posedge clock_in) #1;
        if (busy !== 1'b0) begin
            err_total++;
            end_sim();
        end
        // Load pulse stands for the one cycle after the search ends
        chk("load", 8'h01, {7'h0, load});
        @(posedge clock_in) #1 chk("load_end", 8'h00, {7'h0, load});
        @(posedge clock_in) #1 chk("offset", 8'h60, mag);
        chk("sign", 8'h00, {7'h0, sign});
        chk("cal_flag", 8'h01, {7'h0, cflag});
        chk("cal_irq", 8'h01, {7'h0, irq});
        rd_reg(8'hdc, v);
        chk("done", 8'h01, v);
        // Writing zero keeps the flag, writing one clears it
        wr_reg(8'hdc, 8'h00);
        rd_reg(8'hdc, v);
        chk("done_kept", 8'h01, v);
        wr_reg(8'hdc, 8'h01);
        rd_reg(8'hdc, v);
        chk("done_clr", 8'h00, v);
        // Zero results trim the offset only while enabled, down to 49
        xtalk = 8'h32;
        repeat (40) @(posedge clock_in);
        #1 chk("no_trim", 8'h60, mag);
        wr_reg(8'hd9, 8'h58);
        repeat (400) @(posedge clock_in);
        #1 chk("trimmed", 8'h31, mag);
        // Reset in mid-run restores the defaults
        srst_in = 1'b1;
        repeat (2) @(posedge clock_in);
        #1 srst_in = 1'b0;
        rd_reg(8'hd9, v);
        chk("cfg_rst", 8'h50, v);
        rd_reg(8'hdd, v);
        chk("ien_rst", 8'h00, v);
        end_sim();
    end
endmodule
`default_nettype wire
